//--- logic/llf_pkg.sv
// Package for the link-loss failsafe and digital input configuration block.
// Assumes a 250 MHz ref_clk and a classic Wishbone register port.
package llf_pkg;
  localparam int unsigned LLF_CLK_HZ = 250000000;
  // Link-loss step in milliseconds
  localparam int unsigned LLF_STEP_MS = 280;
  localparam longint unsigned LLF_STEP_CYC_L = longint'(LLF_STEP_MS) * LLF_CLK_HZ / 1000;
  localparam int unsigned LLF_STEP_CYC = int'(LLF_STEP_CYC_L);
  localparam int unsigned LLF_NUM_DI = 2;

  // Register byte offsets
  localparam logic [7:0] LLF_OFF_CTRL = 8'h00;
  localparam logic [7:0] LLF_OFF_DICFG = 8'h04;
  localparam logic [7:0] LLF_OFF_STATUS = 8'h08;
  localparam logic [7:0] LLF_OFF_COUNT0 = 8'h0C;
  localparam logic [7:0] LLF_OFF_COUNT1 = 8'h10;

  // CTRL fields
  localparam int unsigned LLF_CTRL_DELAY_LSB = 0;
  localparam int unsigned LLF_CTRL_DO0_LSB = 8;
  localparam int unsigned LLF_CTRL_DO1_LSB = 10;
  localparam int unsigned LLF_CTRL_COIL_LSB = 12;
  // DICFG fields, per input i at base 8*i
  localparam int unsigned LLF_DI_EDGE_BIT = 0;
  localparam int unsigned LLF_DI_TERM_BIT = 1;
  localparam int unsigned LLF_DI_PULL_LSB = 2;
  localparam int unsigned LLF_DI_STRIDE = 8;

  // Reset values
  localparam logic [7:0] LLF_DELAY_RST = 8'h00;
  localparam logic [1:0] LLF_DODEF_RST = 2'h0;
  localparam logic [1:0] LLF_PULL_RST = 2'h0;

  // Output default choices
  localparam logic [1:0] LLF_DODEF_ON = 2'h0;
  localparam logic [1:0] LLF_DODEF_OFF = 2'h1;
  localparam logic [1:0] LLF_DODEF_KEEP = 2'h2;
  // Pull choices
  localparam logic [1:0] LLF_PULL_UP = 2'h0;
  localparam logic [1:0] LLF_PULL_DOWN = 2'h1;
  localparam logic [1:0] LLF_PULL_FLOAT = 2'h2;
  // Length of the restart pulse in cycles
  localparam int unsigned LLF_REBOOT_CYC = 16;

  typedef struct packed {
    logic edge_rise;
    logic term_en;
    logic [1:0] pull;
  } llf_dicfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } llf_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } llf_wb_rsp_t;

  typedef enum logic [1:0] {
    LLF_LINK_UP,
    LLF_LINK_WAIT,
    LLF_LINK_FAILSAFE
  } llf_state_t;
endpackage

//--- logic/llf_edge_counter.sv
// Per-input edge counter with a two-flop synchroniser.
// Assumes the input pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module llf_edge_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic edge_rise,
  output logic [15:0] count
);
  import llf_pkg::*;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [15:0] count_r;
  wire rise_w = sync2_r & ~prev_r;
  wire fall_w = ~sync2_r & prev_r;
  wire hit_w = edge_rise ? rise_w : fall_w;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      count_r <= 16'h0000;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      if (hit_w) begin
        count_r <= count_r + 16'h0001; // [RULE4]
      end
    end
  end
  assign count = count_r;
endmodule

//--- logic/llf_top.sv
// Link-loss failsafe timer and digital input configuration, Wishbone slave.
// Assumes link_ok_in is a level from another domain, high while polls arrive.
// Operation
// RULE1: After link loss, wait the programmed delay, then apply output defaults.
// RULE2: Delay counts in 0.28 second steps; wait is count times step.
// RULE3: Delay count is eight bits, 0 through 255.
// RULE4: Each input counter advances on falling or rising edge; falling after reset.
// RULE5: Each input has a 125 ohm termination enable, off after reset.
// RULE6: Each input has pull-up, pull-down or float select; pull-up default.
// RULE7: Changing the pull selection restarts the device automatically.
// RULE8: At power-up and failsafe, outputs take default on, off or unchanged.
// RULE9: Timer restarts when link returns; count zero enters failsafe at once.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module llf_top (
  input wire logic ref_clk,
  input wire logic rst,
  input llf_pkg::llf_wb_req_t wb_req,
  output llf_pkg::llf_wb_rsp_t wb_rsp,
  input wire logic link_ok_in,
  input wire logic [1:0] digital_input_in,
  output logic digital_output_one,
  output logic digital_output_two,
  output logic [1:0] term_en,
  output logic [1:0] pull_up_en,
  output logic [1:0] pull_down_en,
  output logic failsafe,
  output logic reboot_req
);
  import llf_pkg::*;

  logic [7:0] delay_r;
  logic [1:0] dodef_r [2];
  logic [1:0] coil_r;
  llf_dicfg_t dicfg_r [2];
  logic [15:0] count_w [2];
  logic ack_r;
  logic [31:0] rdat_r;
  logic link_s1_r;
  logic link_s2_r;
  llf_state_t state_r;
  llf_state_t state_nxt;
  logic [31:0] tick_r;
  logic [7:0] steps_r;
  logic [4:0] reboot_cnt_r;
  logic reboot_r;
  wire [1:0] dout_w;
  wire [1:0] term_w;
  wire [1:0] pu_w;
  wire [1:0] pd_w;
  logic fs_r;
  logic pwr_up_r;

  // Bus decode
  wire acc_w = wb_req.cyc & wb_req.stb & ~ack_r;
  wire wr_w = acc_w & wb_req.we;
  wire wr_ctrl_w = wr_w & (wb_req.adr == LLF_OFF_CTRL);
  wire wr_di_w = wr_w & (wb_req.adr == LLF_OFF_DICFG);
  wire [31:0] status_w = {29'h00000000, reboot_r, fs_r, link_s2_r};
  wire [31:0] ctrl_w = {18'h00000, coil_r, dodef_r[1], dodef_r[0], delay_r};
  wire [31:0] di_w;
  wire [31:0] rd_w;
  wire [1:0] pull_change_w;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_di
      localparam int unsigned B = gi * LLF_DI_STRIDE;
      assign di_w[B +: 8] = {4'h0, dicfg_r[gi].pull, dicfg_r[gi].term_en,
                             dicfg_r[gi].edge_rise};
      assign pull_change_w[gi] = wr_di_w & wb_req.sel[gi]
        & (wb_req.dat[B + LLF_DI_PULL_LSB +: 2] != dicfg_r[gi].pull); // [RULE7]
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          dicfg_r[gi].edge_rise <= 1'b0; // [RULE4]
          dicfg_r[gi].term_en <= 1'b0; // [RULE5]
          dicfg_r[gi].pull <= LLF_PULL_RST; // [RULE6]
        end else if (wr_di_w & wb_req.sel[gi]) begin
          dicfg_r[gi].edge_rise <= wb_req.dat[B + LLF_DI_EDGE_BIT];
          dicfg_r[gi].term_en <= wb_req.dat[B + LLF_DI_TERM_BIT];
          dicfg_r[gi].pull <= wb_req.dat[B + LLF_DI_PULL_LSB +: 2];
        end
      end
      llf_edge_counter u_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(digital_input_in[gi]),
        .edge_rise(dicfg_r[gi].edge_rise),
        .count(count_w[gi])
      );
    end
  endgenerate
  assign di_w[31:16] = 16'h0000;

  assign rd_w = (wb_req.adr == LLF_OFF_CTRL) ? ctrl_w :
                (wb_req.adr == LLF_OFF_DICFG) ? di_w :
                (wb_req.adr == LLF_OFF_STATUS) ? status_w :
                (wb_req.adr == LLF_OFF_COUNT0) ? {16'h0000, count_w[0]} :
                (wb_req.adr == LLF_OFF_COUNT1) ? {16'h0000, count_w[1]} :
                32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= acc_w;
      rdat_r <= acc_w ? rd_w : 32'h00000000;
    end
  end
  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

  // Control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      delay_r <= LLF_DELAY_RST;
      dodef_r[0] <= LLF_DODEF_RST;
      dodef_r[1] <= LLF_DODEF_RST;
      coil_r <= 2'h0;
    end else if (wr_ctrl_w) begin
      if (wb_req.sel[0]) begin
        delay_r <= wb_req.dat[LLF_CTRL_DELAY_LSB +: 8]; // [RULE3]
      end
      if (wb_req.sel[1]) begin
        dodef_r[0] <= wb_req.dat[LLF_CTRL_DO0_LSB +: 2];
        dodef_r[1] <= wb_req.dat[LLF_CTRL_DO1_LSB +: 2];
        coil_r <= wb_req.dat[LLF_CTRL_COIL_LSB +: 2];
      end
    end
  end

  // Link state synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Link taken as good until a loss is seen, so reset gives no false failsafe
      link_s1_r <= 1'b1;
      link_s2_r <= 1'b1;
    end else begin
      link_s1_r <= link_ok_in;
      link_s2_r <= link_s1_r;
    end
  end

  // Link-loss timer
  wire step_done_w = (tick_r == LLF_STEP_CYC - 1);
  wire wait_done_w = (delay_r == 8'h00) | (step_done_w & (steps_r == delay_r - 8'h01));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LLF_LINK_UP: begin
        if (!link_s2_r) begin
          state_nxt = (delay_r == 8'h00) ? LLF_LINK_FAILSAFE : LLF_LINK_WAIT; // [RULE9]
        end
      end
      LLF_LINK_WAIT: begin
        if (link_s2_r) begin
          state_nxt = LLF_LINK_UP; // [RULE9]
        end else if (wait_done_w) begin
          state_nxt = LLF_LINK_FAILSAFE; // [RULE1]
        end
      end
      LLF_LINK_FAILSAFE: begin
        if (link_s2_r) begin
          state_nxt = LLF_LINK_UP;
        end
      end
      default: state_nxt = LLF_LINK_UP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= LLF_LINK_UP;
      tick_r <= 32'h00000000;
      steps_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r != LLF_LINK_WAIT || state_nxt != LLF_LINK_WAIT) begin
        tick_r <= 32'h00000000; // [RULE9]
        steps_r <= 8'h00;
      end else if (step_done_w) begin
        tick_r <= 32'h00000000; // [RULE2]
        steps_r <= steps_r + 8'h01;
      end else begin
        tick_r <= tick_r + 32'h00000001;
      end
    end
  end

  // Outputs: defaults at power-up and on failsafe entry, coils otherwise
  wire fs_enter_w = (state_nxt == LLF_LINK_FAILSAFE) & (state_r != LLF_LINK_FAILSAFE);
  wire apply_def_w = pwr_up_r | fs_enter_w;
  // Coil writes are ignored while the failsafe condition holds
  wire coil_wr_w = (state_r != LLF_LINK_FAILSAFE) & wr_ctrl_w & wb_req.sel[1];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_up_r <= 1'b1;
      fs_r <= 1'b0;
    end else begin
      pwr_up_r <= 1'b0;
      fs_r <= (state_nxt == LLF_LINK_FAILSAFE);
    end
  end

  // Per-channel output and input pin drive
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic out_r;
      logic term_pin_r;
      logic pu_pin_r;
      logic pd_pin_r;
      wire def_on_w = (dodef_r[gi] == LLF_DODEF_ON);
      wire def_off_w = (dodef_r[gi] == LLF_DODEF_OFF);
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          out_r <= 1'b1; // [RULE8]
        end else if (apply_def_w) begin
          if (def_on_w) begin
            out_r <= 1'b1; // [RULE8]
          end else if (def_off_w) begin
            out_r <= 1'b0;
          end
        end else if (coil_wr_w) begin
          out_r <= wb_req.dat[LLF_CTRL_COIL_LSB + gi];
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          term_pin_r <= 1'b0;
          pu_pin_r <= 1'b0;
          pd_pin_r <= 1'b0;
        end else begin
          term_pin_r <= dicfg_r[gi].term_en; // [RULE5]
          pu_pin_r <= (dicfg_r[gi].pull == LLF_PULL_UP); // [RULE6]
          pd_pin_r <= (dicfg_r[gi].pull == LLF_PULL_DOWN);
        end
      end
      assign dout_w[gi] = out_r;
      assign term_w[gi] = term_pin_r;
      assign pu_w[gi] = pu_pin_r;
      assign pd_w[gi] = pd_pin_r;
    end
  endgenerate

  // Restart pulse; a new pull change re-arms it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reboot_r <= 1'b0;
      reboot_cnt_r <= 5'h00;
    end else begin
      if (|pull_change_w) begin
        reboot_r <= 1'b1; // [RULE7]
        reboot_cnt_r <= 5'(LLF_REBOOT_CYC - 1);
      end else if (reboot_cnt_r != 5'h00) begin
        reboot_cnt_r <= reboot_cnt_r - 5'h01;
      end else begin
        reboot_r <= 1'b0;
      end
    end
  end

  assign digital_output_one = dout_w[0];
  assign digital_output_two = dout_w[1];
  assign term_en = term_w;
  assign pull_up_en = pu_w;
  assign pull_down_en = pd_w;
  assign failsafe = fs_r;
  assign reboot_req = reboot_r;
endmodule

//--- test/llf_checker.sv
// Port checker for the link-loss failsafe block.
// Assumes ports of llf_top; attached by bind below.
`timescale 1ns/1ps
module llf_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input llf_pkg::llf_wb_req_t wb_req,
  input llf_pkg::llf_wb_rsp_t wb_rsp,
  input wire logic link_ok_in,
  input wire logic [1:0] pull_up_en,
  input wire logic [1:0] pull_down_en,
  input wire logic failsafe,
  input wire logic reboot_req
);
  import llf_pkg::*;
  wire dicfg_wr = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == LLF_OFF_DICFG;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ack_one_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_ack_answers_req: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not acknowledged next cycle");
  a_dat_idle_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("read data not zero outside ack");
  a_failsafe_needs_loss: assert property ($rose(failsafe) |-> !$past(link_ok_in, 3))
    else $error("failsafe without link loss");
  a_failsafe_exit: assert property (link_ok_in [*6] |-> !failsafe)
    else $error("failsafe held with link good");
  a_pull_exclusive: assert property ((pull_up_en & pull_down_en) == 2'h0)
    else $error("pull-up and pull-down both on");
  a_reboot_length: assert property ($rose(reboot_req) |-> reboot_req [*8])
    else $error("restart pulse too short");
  a_reboot_cause: assert property ($rose(reboot_req) |->
    $past(dicfg_wr, 1) || $past(dicfg_wr, 2) || $past(dicfg_wr, 3))
    else $error("restart without config write");
endmodule
bind llf_top llf_checker chk_u (.ref_clk, .rst, .wb_req, .wb_rsp, .link_ok_in, .pull_up_en,
  .pull_down_en, .failsafe, .reboot_req);

//--- test/llf_link_model.sv
// Polling master seen through the radio link as a link-good level.
// Assumes the bench says whether polls keep arriving.
`timescale 1ns/1ps
module llf_link_model (
  input wire logic ref_clk,
  input wire logic polling,
  output logic link_ok = 1'b1
);
  always @(posedge ref_clk) link_ok <= polling;
endmodule

//--- test/test_link_loss_failsafe_and_input_config.sv
// Self-checking bench for llf_top over Wishbone.
// Assumes the link model stands at the far side.
`timescale 1ns/1ps
module test_link_loss_failsafe_and_input_config;
  import llf_pkg::*;
  logic ref_clk, rst, poll, link_ok, do1, do2, fs, rb;
  logic [1:0] pins, term, pu, pd;
  llf_wb_req_t req;
  llf_wb_rsp_t rsp;
  logic [31:0] q;
  int err_total = 0, n_compared = 0;
  llf_link_model link_u (.ref_clk(ref_clk), .polling(poll), .link_ok(link_ok));
  llf_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_req(req), .wb_rsp(rsp),
    .link_ok_in(link_ok), .digital_input_in(pins), .digital_output_one(do1),
    .digital_output_two(do2), .term_en(term), .pull_up_en(pu), .pull_down_en(pd),
    .failsafe(fs), .reboot_req(rb));
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    req <= '0;
    if (rsp.ack !== 1'b1) begin
      chk("ack", 1, 0);
      finish_test;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic wait_fs(input logic v);
    int n;
    n = 0;
    while (fs !== v && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("failsafe", v, fs);
    if (n >= 100) finish_test;
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    chk("outs", 32'hCC, {do1, do2, term, pu, pd});
    rd(LLF_OFF_CTRL, 32'h0);
    rd(LLF_OFF_DICFG, 32'h0);
    rd(LLF_OFF_STATUS, 32'h1);
    wb(1'b1, 8'h20, 32'hFFFF);
    rd(8'h20, 32'h0);
    rd(LLF_OFF_CTRL, 32'h0);
  endtask
  task automatic t_inputs;
    wb(1'b1, LLF_OFF_DICFG, 32'h3);
    @(posedge ref_clk);
    chk("term", 32'h1, term);
    repeat (3) begin
      pins <= 2'h3;
      repeat (4) @(posedge ref_clk);
      pins <= 2'h0;
      repeat (4) @(posedge ref_clk);
    end
    rd(LLF_OFF_COUNT0, 32'h3);
    rd(LLF_OFF_COUNT1, 32'h3);
  endtask
  task automatic t_failsafe;
    wb(1'b1, LLF_OFF_CTRL, 32'h39FF);
    rd(LLF_OFF_CTRL, 32'h39FF);
    poll <= 1'b0;
    repeat (60) @(posedge ref_clk);
    chk("early fs", 32'h0, fs);
    poll <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b1, LLF_OFF_CTRL, 32'h3900);
    repeat (4) @(posedge ref_clk);
    chk("coils", 32'h3, {do1, do2});
    poll <= 1'b0;
    wait_fs(1'b1);
    @(posedge ref_clk);
    chk("defaults", 32'h1, {do1, do2});
    rd(LLF_OFF_STATUS, 32'h2);
    poll <= 1'b1;
    wait_fs(1'b0);
  endtask
  task automatic t_pull;
    int n;
    wb(1'b1, LLF_OFF_DICFG, 32'h7);
    n = 0;
    while (rb !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (rb === 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk("restart len", LLF_REBOOT_CYC, n);
    chk("pulls", 32'h9, {pu, pd});
    wb(1'b1, LLF_OFF_DICFG, 32'h0807);
    repeat (2) @(posedge ref_clk);
    chk("restart again", 32'h1, rb);
    chk("pulls float", 32'h1, {pu, pd});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    pins = 2'h0;
    poll = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_inputs;
    t_failsafe;
    t_pull;
    finish_test;
  end
endmodule
